// file: hdl/cac_pkg.sv
// Shared constants and types for the coordinate and accumulator command logic.
package cac_pkg;
    localparam int          NUM_COORD  = 21;
    localparam int          MAX_COORD  = 20;
    localparam int          FRAME_LEN  = 9;
    localparam logic [7:0]  INS_SET_COORD     = 8'h1e;
    localparam logic [7:0]  INS_GET_COORD     = 8'h1f;
    localparam logic [7:0]  INS_CAPTURE_COORD = 8'h20;
    localparam logic [7:0]  INS_ACCU_X_OP     = 8'h21;
    localparam logic [7:0]  INS_ACCU_TO_COORD = 8'h27;
    localparam logic [7:0]  MOTOR_NVM  = 8'hff;
    localparam logic [7:0]  ST_OK      = 8'h64;
    localparam logic [7:0]  ST_CHKSUM  = 8'h01;
    localparam logic [7:0]  ST_BAD_CMD = 8'h02;
    localparam logic [7:0]  ST_BAD_TYP = 8'h03;
    localparam logic [7:0]  ST_BAD_VAL = 8'h04;
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_ADDR   = 8'h04;
    localparam logic [7:0]  REG_ACC    = 8'h08;
    localparam logic [7:0]  REG_X      = 8'h0c;
    localparam logic [7:0]  REG_STAT   = 8'h10;
    localparam int          CTRL_NVM   = 0;
    localparam logic        NVM_RST    = 1'b0;
    localparam logic [7:0]  ADDR_RST   = 8'h01;
    typedef enum logic [3:0] {
        XOP_ADD, XOP_SUB, XOP_MUL, XOP_DIV, XOP_MOD, XOP_AND,
        XOP_OR, XOP_XOR, XOP_NOT, XOP_LOAD, XOP_SWAP
    } cac_xop_type;
    typedef enum logic [1:0] {ST_IDLE, ST_COPY} cac_state_type;
endpackage

// file: hdl/cac_frame_rx.sv
// Command frame assembler with checksum test.
module cac_frame_rx (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rstn,
    // Byte stream from the link.
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_valid,
    // Assembled frame.
    output logic             frame_valid,
    output logic             frame_sum_ok,
    output logic [7:0]       frame_addr,
    output logic [7:0]       frame_instr,
    output logic [7:0]       frame_type,
    output logic [7:0]       frame_motor,
    output logic [31:0]      frame_value
);
    logic [7:0] byte_reg [0:cac_pkg::FRAME_LEN-2];
    logic [3:0] cnt_reg;
    logic [7:0] sum_reg;
    wire        last = (cnt_reg == 4'(cac_pkg::FRAME_LEN - 1));

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cnt_reg <= 4'h0;
            sum_reg <= 8'h00;
        end else if (rx_valid) begin
            cnt_reg <= last ? 4'h0 : cnt_reg + 4'h1;
            sum_reg <= last ? 8'h00 : sum_reg + rx_byte;
        end
    end

    always_ff @(posedge clock) begin
        if (rx_valid && !last) begin
            byte_reg[cnt_reg[2:0]] <= rx_byte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            frame_valid  <= 1'b0;
            frame_sum_ok <= 1'b0;
        end else begin
            frame_valid  <= rx_valid && last;
            frame_sum_ok <= sum_reg == rx_byte;
        end
    end

    assign frame_addr  = byte_reg[0];
    assign frame_instr = byte_reg[1];
    assign frame_type  = byte_reg[2];
    assign frame_motor = byte_reg[3];
    assign frame_value = {byte_reg[4], byte_reg[5], byte_reg[6], byte_reg[7]};
endmodule // cac_frame_rx

// file: hdl/cac_alu.sv
// Accumulator and X register arithmetic and logic unit.
module cac_alu (
    // Operation and operands.
    input  wire logic [7:0]  op,
    input  wire logic [31:0] acc,
    input  wire logic [31:0] x,
    // Results.
    output logic [31:0]      acc_out,
    output logic [31:0]      x_out,
    output logic             op_ok
);
    always_comb begin
        acc_out = acc;
        x_out   = x;
        op_ok   = 1'b1;
        case (op)
            8'(cac_pkg::XOP_ADD): acc_out = acc + x;
            8'(cac_pkg::XOP_SUB): acc_out = acc - x;
            8'(cac_pkg::XOP_MUL): acc_out = acc * x;
            8'(cac_pkg::XOP_DIV): if (x != 32'h0) acc_out = $signed(acc) / $signed(x);
            8'(cac_pkg::XOP_MOD): if (x != 32'h0) acc_out = $signed(acc) % $signed(x);
            8'(cac_pkg::XOP_AND): acc_out = acc & x;
            8'(cac_pkg::XOP_OR):  acc_out = acc | x;
            8'(cac_pkg::XOP_XOR): acc_out = acc ^ x;
            8'(cac_pkg::XOP_NOT): x_out = ~x;
            8'(cac_pkg::XOP_LOAD): x_out = acc;
            8'(cac_pkg::XOP_SWAP): begin
                acc_out = x;
                x_out   = acc;
            end
            default: op_ok = 1'b0;
        endcase
    end
endmodule // cac_alu

// file: hdl/cac_cmd_exec.sv
// Coordinate array and accumulator command executor.
module cac_cmd_exec #(
    parameter int NUM_AXES = 1
) (
    // Clock and reset.
    input  wire logic                     clock,
    input  wire logic                     rstn,
    // Command link bytes.
    input  wire logic [7:0]               rx_byte,
    input  wire logic                     rx_valid,
    // Stored program commands.
    input  wire logic                     prog_valid,
    output logic                          prog_ready,
    input  wire logic [7:0]               prog_instr,
    input  wire logic [7:0]               prog_type,
    input  wire logic [7:0]               prog_motor,
    input  wire logic [31:0]              prog_value,
    // Actual axis positions.
    input  wire logic [NUM_AXES-1:0][31:0] act_pos,
    // Direct mode reply.
    output logic                          reply_valid,
    output logic [7:0]                    reply_instr,
    output logic [7:0]                    reply_status,
    output logic [31:0]                   reply_value,
    // Register port.
    input  wire logic [7:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata
);
    localparam int DEPTH = NUM_AXES * cac_pkg::NUM_COORD;
    localparam int IW    = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [31:0] ram [0:DEPTH-1];
    logic [31:0] nvm [0:DEPTH-1];
    cac_pkg::cac_state_type state_reg;
    logic [4:0]  coord_reg, lo_reg, hi_reg;
    logic [7:0]  axis_reg;
    logic        restore_reg, dir_reg;
    logic [7:0]  instr_reg;
    logic        nvm_keep_reg;
    logic [7:0]  addr_reg;
    logic [31:0] acc_reg, x_reg;

    logic        f_valid, f_ok;
    logic [7:0]  f_addr, f_instr, f_type, f_motor;
    logic [31:0] f_value;
    logic        use_dir, go;
    logic [7:0]  c_ins, c_type, c_motor;
    logic [31:0] c_val, rd_val, alu_acc, alu_x;
    logic        sel_ok, alu_ok, nvm_form;
    logic [IW-1:0] idx, cp_a;
    logic        ram_we, nvm_we, acc_we, x_we, start_copy, rep_now;
    logic [IW-1:0] ram_wa, nvm_wa;
    logic [31:0] ram_wd, nvm_wd, acc_wd, x_wd, rep_val;
    logic [4:0]  nvm_wc;
    logic [7:0]  st;
    logic        copy_last;

    cac_frame_rx u_rx (
        .clock        (clock),
        .rstn         (rstn),
        .rx_byte      (rx_byte),
        .rx_valid     (rx_valid),
        .frame_valid  (f_valid),
        .frame_sum_ok (f_ok),
        .frame_addr   (f_addr),
        .frame_instr  (f_instr),
        .frame_type   (f_type),
        .frame_motor  (f_motor),
        .frame_value  (f_value)
    );

    cac_alu u_alu (
        .op      (c_type),
        .acc     (acc_reg),
        .x       (x_reg),
        .acc_out (alu_acc),
        .x_out   (alu_x),
        .op_ok   (alu_ok)
    );

    // A frame always wins the slot, so the host never sees a silent drop while idle.
    assign use_dir    = f_valid && (f_addr == addr_reg) && (state_reg == cac_pkg::ST_IDLE);
    assign prog_ready = (state_reg == cac_pkg::ST_IDLE) && !f_valid;
    assign go         = use_dir || (prog_valid && prog_ready);
    assign c_ins      = use_dir ? f_instr : prog_instr;
    assign c_type     = use_dir ? f_type : prog_type;
    assign c_motor    = use_dir ? f_motor : prog_motor;
    assign c_val      = use_dir ? f_value : prog_value;
    assign sel_ok     = (int'(c_type) <= cac_pkg::MAX_COORD) && (int'(c_motor) < NUM_AXES);
    assign idx        = IW'(int'(c_motor) * cac_pkg::NUM_COORD + int'(c_type));
    assign cp_a       = IW'(int'(axis_reg) * cac_pkg::NUM_COORD + int'(coord_reg));
    assign rd_val     = sel_ok ? ram[idx] : 32'h0;
    assign nvm_form   = (c_motor == cac_pkg::MOTOR_NVM)
                        && (c_ins == cac_pkg::INS_SET_COORD || c_ins == cac_pkg::INS_GET_COORD);
    assign copy_last  = (coord_reg == hi_reg) && (int'(axis_reg) == NUM_AXES - 1);

    always_comb begin
        st = cac_pkg::ST_OK;
        ram_we = 1'b0;
        ram_wa = idx;
        ram_wd = c_val;
        acc_we = 1'b0;
        acc_wd = alu_acc;
        x_we = 1'b0;
        start_copy = 1'b0;
        rep_val = 32'h0;
        if (state_reg == cac_pkg::ST_COPY) begin
            ram_we = restore_reg && coord_reg != 5'h0;
            ram_wa = cp_a;
            ram_wd = nvm[cp_a];
        end else if (go && use_dir && !f_ok) begin
            st = cac_pkg::ST_CHKSUM;
        end else if (go && nvm_form) begin
            if (int'(c_type) > cac_pkg::MAX_COORD) st = cac_pkg::ST_BAD_TYP;
            else if (c_val != 32'h0) st = cac_pkg::ST_BAD_VAL;
            else start_copy = 1'b1;
        end else if (go) begin
            case (c_ins)
                cac_pkg::INS_SET_COORD, cac_pkg::INS_CAPTURE_COORD,
                cac_pkg::INS_ACCU_TO_COORD, cac_pkg::INS_GET_COORD: begin
                    if (!sel_ok) begin
                        st = (int'(c_type) > cac_pkg::MAX_COORD) ? cac_pkg::ST_BAD_TYP
                                                                 : cac_pkg::ST_BAD_VAL;
                    end else if (c_ins == cac_pkg::INS_GET_COORD) begin
                        rep_val = rd_val;
                        acc_we  = !use_dir;
                        acc_wd  = rd_val;
                    end else begin
                        ram_we = 1'b1;
                        if (c_ins == cac_pkg::INS_CAPTURE_COORD) ram_wd = act_pos[c_motor];
                        if (c_ins == cac_pkg::INS_ACCU_TO_COORD) ram_wd = acc_reg;
                        rep_val = (c_ins == cac_pkg::INS_CAPTURE_COORD) ? ram_wd : 32'h0;
                    end
                end
                cac_pkg::INS_ACCU_X_OP: begin
                    acc_we = alu_ok;
                    x_we   = alu_ok;
                    if (!alu_ok) st = cac_pkg::ST_BAD_TYP;
                end
                default: st = cac_pkg::ST_BAD_CMD;
            endcase
        end
    end

    // The NVM shadow follows each stored write to entries other than zero when saving is on, or a save walk.
    always_comb begin
        nvm_we = 1'b0;
        nvm_wa = ram_wa;
        nvm_wd = ram_wd;
        nvm_wc = (state_reg == cac_pkg::ST_COPY) ? coord_reg : c_type[4:0];
        if (state_reg == cac_pkg::ST_COPY) begin
            nvm_we = !restore_reg && coord_reg != 5'h0;
            nvm_wa = cp_a;
            nvm_wd = ram[cp_a];
        end else if (ram_we && nvm_keep_reg && c_type != 8'h0) begin
            nvm_we = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (ram_we) ram[ram_wa] <= ram_wd;
    end

    // The shadow holds its contents through reset, as a non-volatile store would.
    always_ff @(posedge clock) begin
        if (nvm_we) nvm[nvm_wa] <= nvm_wd;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg <= cac_pkg::ST_IDLE;
            coord_reg <= 5'h0;
            lo_reg <= 5'h0;
            hi_reg <= 5'h0;
            axis_reg <= 8'h0;
            restore_reg <= 1'b0;
            dir_reg <= 1'b0;
            instr_reg <= 8'h0;
        end else if (start_copy) begin
            state_reg <= cac_pkg::ST_COPY;
            lo_reg <= (c_type == 8'h0) ? 5'h1 : c_type[4:0];
            hi_reg <= (c_type == 8'h0) ? 5'(cac_pkg::MAX_COORD) : c_type[4:0];
            coord_reg <= (c_type == 8'h0) ? 5'h1 : c_type[4:0];
            axis_reg <= 8'h0;
            restore_reg <= c_ins == cac_pkg::INS_GET_COORD;
            dir_reg <= use_dir;
            instr_reg <= c_ins;
        end else if (state_reg == cac_pkg::ST_COPY) begin
            if (copy_last) state_reg <= cac_pkg::ST_IDLE;
            if (coord_reg == hi_reg) begin
                coord_reg <= lo_reg;
                axis_reg <= axis_reg + 8'h1;
            end else begin
                coord_reg <= coord_reg + 5'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            acc_reg <= 32'h0;
            x_reg <= 32'h0;
        end else begin
            if (acc_we) acc_reg <= acc_wd;
            if (x_we) x_reg <= alu_x;
        end
    end

    assign rep_now = (use_dir && !start_copy)
                     || (state_reg == cac_pkg::ST_COPY && copy_last && dir_reg);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            reply_valid <= 1'b0;
            reply_instr <= 8'h0;
            reply_status <= 8'h0;
            reply_value <= 32'h0;
        end else begin
            reply_valid <= rep_now;
            if (rep_now) begin
                reply_instr  <= use_dir ? c_ins : instr_reg;
                reply_status <= use_dir ? st : cac_pkg::ST_OK;
                reply_value  <= use_dir ? rep_val : 32'h0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            nvm_keep_reg <= cac_pkg::NVM_RST;
            addr_reg <= cac_pkg::ADDR_RST;
        end else if (reg_wr) begin
            if (reg_addr == cac_pkg::REG_CTRL) nvm_keep_reg <= reg_wdata[cac_pkg::CTRL_NVM];
            if (reg_addr == cac_pkg::REG_ADDR) addr_reg <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || !reg_rd) begin
            reg_rdata <= 32'h0;
        end else begin
            case (reg_addr)
                cac_pkg::REG_CTRL: reg_rdata <= {31'h0, nvm_keep_reg};
                cac_pkg::REG_ADDR: reg_rdata <= {24'h0, addr_reg};
                cac_pkg::REG_ACC:  reg_rdata <= acc_reg;
                cac_pkg::REG_X:    reg_rdata <= x_reg;
                cac_pkg::REG_STAT: reg_rdata <= {31'h0, state_reg == cac_pkg::ST_COPY};
                default:           reg_rdata <= 32'h0;
            endcase
        end
    end

    wire get_ok = go && !nvm_form && c_ins == cac_pkg::INS_GET_COORD && sel_ok
                  && (!use_dir || f_ok);
    wire cx     = go && !use_dir && c_ins == cac_pkg::INS_ACCU_X_OP;

    property p_get_dir;
        @(posedge clock) disable iff (!rstn)
        use_dir && get_ok |=> reply_valid && reply_status == cac_pkg::ST_OK
            && reply_value == $past(rd_val) && acc_reg == $past(acc_reg);
    endproperty
    a_get_dir: assert property (p_get_dir) else $error("direct read reply wrong");
    property p_get_prog;
        @(posedge clock) disable iff (!rstn)
        !use_dir && get_ok |=> acc_reg == $past(rd_val) && !reply_valid;
    endproperty
    a_get_prog: assert property (p_get_prog) else $error("program read not in accu");
    property p_store;
        @(posedge clock) disable iff (!rstn)
        ram_we && state_reg == cac_pkg::ST_IDLE |=> ram[$past(ram_wa)] == $past(ram_wd);
    endproperty
    a_store: assert property (p_store) else $error("coordinate not stored");
    property p_accu_store;
        @(posedge clock) disable iff (!rstn)
        ram_we && state_reg == cac_pkg::ST_IDLE && c_ins == cac_pkg::INS_ACCU_TO_COORD
            |=> ram[$past(ram_wa)] == $past(acc_reg);
    endproperty
    a_accu_store: assert property (p_accu_store) else $error("accu copy wrong");
    property p_nvm_zero;
        @(posedge clock) disable iff (!rstn)
        nvm_we |-> nvm_wc != 5'h0;
    endproperty
    a_nvm_zero: assert property (p_nvm_zero) else $error("entry zero reached nvm");
    property p_ram_only;
        @(posedge clock) disable iff (!rstn)
        nvm_we && state_reg == cac_pkg::ST_IDLE |-> nvm_keep_reg;
    endproperty
    a_ram_only: assert property (p_ram_only) else $error("nvm written in ram mode");
    property p_add;
        @(posedge clock) disable iff (!rstn)
        cx && c_type == 8'h0 |=> acc_reg == $past(acc_reg) + $past(x_reg);
    endproperty
    a_add: assert property (p_add) else $error("add wrong");
    property p_div0;
        @(posedge clock) disable iff (!rstn)
        cx && (c_type == 8'h3 || c_type == 8'h4) && x_reg == 32'h0 |=> $stable(acc_reg);
    endproperty
    a_div0: assert property (p_div0) else $error("divide by zero changed accu");
    property p_swap;
        @(posedge clock) disable iff (!rstn)
        cx && c_type == 8'ha |=> acc_reg == $past(x_reg) && x_reg == $past(acc_reg);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");
    property p_restore_all;
        @(posedge clock) disable iff (!rstn)
        start_copy && use_dir && c_type == 8'h0 |=> ##[19:1000] reply_valid;
    endproperty
    a_restore_all: assert property (p_restore_all) else $error("copy walk no reply");

    c_restore: cover property (@(posedge clock) start_copy && c_ins == cac_pkg::INS_GET_COORD);
    c_save:    cover property (@(posedge clock) start_copy && c_ins == cac_pkg::INS_SET_COORD);
    c_xop:     cover property (@(posedge clock) cx && c_type == 8'h2);
    c_capture: cover property (@(posedge clock)
        use_dir && c_ins == cac_pkg::INS_CAPTURE_COORD && ram_we);
endmodule // cac_cmd_exec

// file: dv/cac_host_model.sv
// Host model that sends command frames to the device over the byte link.
module cac_host_model (
    // Clock.
    input  wire logic       clock,
    // Byte link towards the device.
    output logic      [7:0] rx_byte,
    output logic            rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rx_byte  = 8'h00;
        rx_valid = 1'b0;
    end

    // An idle link shows the inverse of the last byte, so a stale byte never looks valid.
    task automatic send_frame(input logic [7:0] adr, ins, typ, mot, input logic [31:0] val,
                              input bit bad, input int gap);
        logic [7:0] f [9];
        f = '{adr, ins, typ, mot, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        for (int k = 0; k < 8; k++) begin
            f[8] = f[8] + f[k];
        end
        if (bad) begin
            f[8] = f[8] + 8'h01;
        end
        @(posedge clock);
        for (int k = 0; k < 9; k++) begin
            if (gap > 0 && k > 0) begin
                rx_valid <= 1'b0;
                rx_byte  <= ~f[k-1];
                repeat (gap) @(posedge clock);
            end
            rx_byte  <= f[k];
            rx_valid <= 1'b1;
            @(posedge clock);
        end
        rx_valid <= 1'b0;
        rx_byte  <= ~f[8];
    endtask
endmodule // cac_host_model

// file: dv/testbench.sv
// Self-checking testbench for the coordinate and accumulator command executor.
`define CHECK_EQ(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic             clock = 1'b0;
    logic             rstn = 1'b0;
    logic             rx_valid, prog_valid, prog_ready, reply_valid, reg_wr, reg_rd;
    logic [7:0]       rx_byte, prog_instr, prog_type, prog_motor, reg_addr;
    logic [7:0]       reply_instr, reply_status;
    logic [31:0]      prog_value, reply_value, reg_wdata, reg_rdata;
    logic [1:0][31:0] act_pos = {32'h0000_0064, 32'h0000_0007};
    int               n_fail = 0;
    int               num_checks = 0;
    int               gap = 0;
    bit               bad_sum = 1'b0;

    initial begin
        {prog_valid, prog_instr, prog_type, prog_motor, prog_value} = '0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    end

    always #20 clock = ~clock;

    cac_host_model cac_host_model_i (.clock(clock), .rx_byte(rx_byte), .rx_valid(rx_valid));

    cac_cmd_exec #(.NUM_AXES(2)) cac_cmd_exec_i (
        .clock(clock), .rstn(rstn), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_instr(prog_instr),
        .prog_type(prog_type), .prog_motor(prog_motor), .prog_value(prog_value),
        .act_pos(act_pos), .reply_valid(reply_valid), .reply_instr(reply_instr),
        .reply_status(reply_status), .reply_value(reply_value), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    task automatic give_verdict;
        $display("Checks: %0d, mismatches: %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        `CHECK_EQ(reg_rdata, exp)
    endtask

    // The request is held until prog_ready is seen high at a falling edge, then through the next rising edge.
    task automatic prog(input logic [7:0] ins, typ, mot);
        int i;
        @(posedge clock);
        prog_valid <= 1'b1;
        prog_instr <= ins;
        prog_type  <= typ;
        prog_motor <= mot;
        i = 0;
        @(negedge clock);
        while (prog_ready !== 1'b1 && i < 100) begin
            @(negedge clock);
            i++;
        end
        `CHECK_EQ(prog_ready, 1'b1)
        @(posedge clock);
        prog_valid <= 1'b0;
    endtask

    task automatic cmd(input logic [7:0] ins, typ, mot, input logic [31:0] val,
                       input logic [7:0] st, input logic [31:0] ev, input bit chkv);
        int i;
        cac_host_model_i.send_frame(8'h01, ins, typ, mot, val, bad_sum, gap);
        i = 0;
        do begin
            @(posedge clock);
            #1;
            i++;
        end while (reply_valid !== 1'b1 && i < 200);
        `CHECK_EQ(reply_valid, 1'b1)
        `CHECK_EQ(reply_status, st)
        if (st == cac_pkg::ST_OK) `CHECK_EQ(reply_instr, ins)
        if (chkv) `CHECK_EQ(reply_value, ev)
    endtask

    function automatic logic [31:0] alu_exp(input int t, input logic [31:0] a, x);
        case (t)
            0: return a + x;
            1: return a - x;
            2: return a * x;
            3: return $signed(a) / $signed(x);
            4: return $signed(a) % $signed(x);
            5: return a & x;
            6: return a | x;
            default: return a ^ x;
        endcase
    endfunction

    initial begin
        #(40 * 20000);
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        reg_read(cac_pkg::REG_CTRL, 32'h0000_0000);
        reg_read(cac_pkg::REG_ADDR, 32'h0000_0001);
        reg_read(cac_pkg::REG_ACC, 32'h0000_0000);
        reg_read(8'h40, 32'h0000_0000);
        cmd(cac_pkg::INS_CAPTURE_COORD, 8'h01, 8'h00, 0, cac_pkg::ST_OK, 32'h0000_0007, 1);
        gap = 2;
        cmd(cac_pkg::INS_CAPTURE_COORD, 8'h02, 8'h01, 0, cac_pkg::ST_OK, 32'h0000_0064, 1);
        cmd(cac_pkg::INS_CAPTURE_COORD, 8'h14, 8'h01, 0, cac_pkg::ST_OK, 32'h0000_0064, 1);
        gap = 0;
        cmd(cac_pkg::INS_GET_COORD, 8'h02, 8'h01, 0, cac_pkg::ST_OK, 32'h0000_0064, 1);
        cmd(cac_pkg::INS_GET_COORD, 8'h14, 8'h01, 0, cac_pkg::ST_OK, 32'h0000_0064, 1);
        reg_read(cac_pkg::REG_ACC, 32'h0000_0000);
        prog(cac_pkg::INS_GET_COORD, 8'h01, 8'h00);
        reg_read(cac_pkg::REG_ACC, 32'h0000_0007);
        prog(cac_pkg::INS_ACCU_X_OP, 8'h03, 8'h00);
        reg_read(cac_pkg::REG_ACC, 32'h0000_0007);
        prog(cac_pkg::INS_ACCU_X_OP, 8'h09, 8'h00);
        reg_read(cac_pkg::REG_X, 32'h0000_0007);
        for (int t = 0; t < 8; t++) begin
            prog(cac_pkg::INS_GET_COORD, 8'h02, 8'h01);
            prog(cac_pkg::INS_ACCU_X_OP, 8'(t), 8'h00);
            reg_read(cac_pkg::REG_ACC, alu_exp(t, 32'h0000_0064, 32'h0000_0007));
        end
        prog(cac_pkg::INS_ACCU_X_OP, 8'h08, 8'h00);
        reg_read(cac_pkg::REG_X, 32'hffff_fff8);
        prog(cac_pkg::INS_ACCU_X_OP, 8'h0a, 8'h00);
        reg_read(cac_pkg::REG_ACC, 32'hffff_fff8);
        reg_read(cac_pkg::REG_X, 32'h0000_0063);
        cmd(cac_pkg::INS_ACCU_TO_COORD, 8'h03, 8'h00, 0, cac_pkg::ST_OK, 32'h0, 0);
        cmd(cac_pkg::INS_GET_COORD, 8'h03, 8'h00, 0, cac_pkg::ST_OK, 32'hffff_fff8, 1);
        cmd(cac_pkg::INS_ACCU_X_OP, 8'h00, 8'h00, 0, cac_pkg::ST_OK, 32'h0, 1);
        reg_read(cac_pkg::REG_ACC, 32'h0000_005b);
        cmd(cac_pkg::INS_SET_COORD, 8'h05, 8'h01, 32'h1234, cac_pkg::ST_OK, 32'h0, 1);
        cmd(cac_pkg::INS_GET_COORD, 8'h05, 8'h01, 0, cac_pkg::ST_OK, 32'h0000_1234, 1);
        cmd(cac_pkg::INS_GET_COORD, 8'h01, 8'h02, 0, cac_pkg::ST_BAD_VAL, 32'h0, 0);
        cmd(8'h1b, 8'h00, 8'h00, 0, cac_pkg::ST_BAD_CMD, 32'h0, 0);
        reg_write(cac_pkg::REG_CTRL, 32'h0000_0001);
        reg_read(cac_pkg::REG_CTRL, 32'h0000_0001);
        cmd(cac_pkg::INS_CAPTURE_COORD, 8'h04, 8'h00, 0, cac_pkg::ST_OK, 32'h0000_0007, 1);
        cmd(cac_pkg::INS_CAPTURE_COORD, 8'h00, 8'h00, 0, cac_pkg::ST_OK, 32'h0000_0007, 1);
        reg_write(cac_pkg::REG_CTRL, 32'h0000_0000);
        act_pos[0] <= 32'h0000_0055;
        cmd(cac_pkg::INS_CAPTURE_COORD, 8'h04, 8'h00, 0, cac_pkg::ST_OK, 32'h0000_0055, 1);
        cmd(cac_pkg::INS_CAPTURE_COORD, 8'h00, 8'h00, 0, cac_pkg::ST_OK, 32'h0000_0055, 1);
        cmd(cac_pkg::INS_GET_COORD, 8'h04, 8'hff, 0, cac_pkg::ST_OK, 32'h0, 0);
        cmd(cac_pkg::INS_GET_COORD, 8'h04, 8'h00, 0, cac_pkg::ST_OK, 32'h0000_0007, 1);
        cmd(cac_pkg::INS_SET_COORD, 8'h03, 8'hff, 0, cac_pkg::ST_OK, 32'h0, 0);
        cmd(cac_pkg::INS_CAPTURE_COORD, 8'h03, 8'h00, 0, cac_pkg::ST_OK, 32'h0000_0055, 1);
        cmd(cac_pkg::INS_GET_COORD, 8'h03, 8'hff, 0, cac_pkg::ST_OK, 32'h0, 0);
        cmd(cac_pkg::INS_GET_COORD, 8'h03, 8'h00, 0, cac_pkg::ST_OK, 32'hffff_fff8, 1);
        cmd(cac_pkg::INS_CAPTURE_COORD, 8'h04, 8'h00, 0, cac_pkg::ST_OK, 32'h0000_0055, 1);
        cmd(cac_pkg::INS_GET_COORD, 8'h00, 8'hff, 0, cac_pkg::ST_OK, 32'h0, 0);
        cmd(cac_pkg::INS_GET_COORD, 8'h04, 8'h00, 0, cac_pkg::ST_OK, 32'h0000_0007, 1);
        cmd(cac_pkg::INS_GET_COORD, 8'h00, 8'h00, 0, cac_pkg::ST_OK, 32'h0000_0055, 1);
        cmd(cac_pkg::INS_GET_COORD, 8'h15, 8'h00, 0, cac_pkg::ST_BAD_TYP, 32'h0, 0);
        cac_host_model_i.send_frame(8'h01, cac_pkg::INS_GET_COORD, 8'h00, 8'hff, 0, 1'b0, 0);
        reg_read(cac_pkg::REG_STAT, 32'h0000_0001);
        repeat (50) @(posedge clock);
        reg_read(cac_pkg::REG_STAT, 32'h0000_0000);
        bad_sum = 1'b1;
        cmd(cac_pkg::INS_GET_COORD, 8'h01, 8'h00, 0, cac_pkg::ST_CHKSUM, 32'h0, 0);
        give_verdict();
    end
endmodule // testbench
